// File: logic/osc_consts.vh
// Purpose: register offsets, field positions and reset values of the oscillator control block
// Assumes: 16-bit registers on a plain strobe port
// Notes:   included by osc_ctrl.v
`ifndef OSC_CONSTS_VH
`define OSC_CONSTS_VH
`define OSC_ADDR_OSCCTL      2'h0
`define OSC_ADDR_CLOCK_DIVIDER_CONTROL      2'h1
`define OSC_ADDR_UNLOCK      2'h2
`define OSC_UNLOCK_KEY       16'h55AA
`define OSC_CUR_HI           14
`define OSC_CUR_LO           12
`define OSC_REQ_HI           10
`define OSC_REQ_LO           8
`define OSC_BIT_SELLOCK      7
`define OSC_BIT_PINLOCK      6
`define OSC_BIT_PLLLOCK      5
`define OSC_BIT_FAIL         3
`define OSC_BIT_PRISLEEP     2
`define OSC_BIT_SECEN        1
`define OSC_BIT_SWREQ        0
`define OSC_BIT_ROI          15
`define OSC_RATIO_HI         14
`define OSC_RATIO_LO         12
`define OSC_BIT_RATIO_EN     11
`define OSC_RCPS_HI          10
`define OSC_RCPS_LO          8
`define OSC_SYSPS_HI         7
`define OSC_SYSPS_LO         6
`define OSC_BIT_PLL96_ENABLE        5
`define OSC_BIT_DISPSEL      4
`define OSC_CLOCK_DIVIDER_CONTROL_RST       16'h0100
`define OSC_CLOCK_DIVIDER_CONTROL_WMASK     16'hFFF0
`define OSC_SRC_RC_WITH_PLL_MODE       3'h1
`define OSC_SRC_PRIPLL       3'h3
`define OSC_SETTLE_CYCLES    4'hA
`endif

// File: logic/osc_ctrl.v
// Purpose: oscillator source selection, switch sequencing and clock divider control
// Assumes: all inputs synchronous to mclk; new_clk_tick pulses once per new-source cycle
// Notes:   registers reached over a plain strobe port, read data one cycle after strobe
// Operation
// [RULE1] switching allowed only when switch enable cfg zero
// [RULE2] fail-safe monitor enabled only when field 00
// [RULE3] power-on source from mode and source fields
// [RULE4] erased configuration selects rc with postscaler
// [RULE5] current source read-only at bits 14-12
// [RULE6] requested source writable at bits 10-8
// [RULE7] reset loads both source fields from configuration
// [RULE8] selection lock freezes selections when monitor on
// [RULE9] pin lock needs unlock; one-way blocks clear
// [RULE10] pll lock bit shows pll lock or timer
// [RULE11] pll lock cleared on switch or non-pll mode
// [RULE12] clock fail flag set by hardware, software clears
// [RULE13] primary sleep run bit keeps primary in sleep
// [RULE14] secondary enable bit enables secondary oscillator
// [RULE15] switch request held until switch completes
// [RULE16] recover on interrupt clears ratio apply bit
// [RULE17] ratio field is power-of-two slowdown
// [RULE18] ratio apply bit zero forces 1:1
// [RULE19] rc postscaler divides by 1..256, resets 001
// [RULE20] system postscaler divides by 1,2,4,8
// [RULE21] software avoids divide 4/8 while usb on
// [RULE22] unimplemented control bits read zero
// [RULE23] pll96 enable bit enables the pll
// [RULE24] request for current source is aborted
// [RULE25] wait 10 new-source cycles, then copy source
// [RULE26] switch request ignored while switching disabled
// [RULE27] divider changes take effect at period boundaries; the ratio apply bit acts at once
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/100ps
`include "osc_consts.vh"
module osc_ctrl #(
    parameter RATIO_W = 3
) (
    input  wire        mclk,
    input  wire        rst_b,
    input  wire [1:0]  reg_addr,
    input  wire [15:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [15:0] reg_rdata,
    input  wire [1:0]  switch_monitor_cfg,
    input  wire [1:0]  primary_mode_cfg,
    input  wire [2:0]  initial_source_cfg,
    input  wire        one_way_pin_lock_cfg,
    input  wire        pll_locked,
    input  wire        pll_timer_done,
    input  wire        clock_failed,
    input  wire        new_clk_tick,
    input  wire        irq_any,
    input  wire        sleep_mode,
    input  wire        rc_clk_tick,
    input  wire        sys_clk_tick,
    output wire [2:0]  active_source,
    output wire [1:0]  primary_mode,
    output wire        switch_allowed,
    output wire        fail_safe_monitor,
    output wire        primary_osc_run,
    output wire        secondary_osc_en,
    output wire        pll96_en,
    output wire        display_clk_source_sel,
    output reg         periph_tick,
    output reg         rc_div_tick,
    output reg         sys_div_tick
);
    localparam ST_IDLE   = 3'b001;
    localparam ST_SETTLE = 3'b010;
    localparam ST_DONE   = 3'b100;

    reg  [2:0]  cur_src;
    reg  [2:0]  req_src;
    reg         selection_lock;
    reg         pin_map_lock;
    reg         clock_fail_flag;
    reg         primary_sleep_run;
    reg         secondary_enable;
    reg         switch_request;
    reg         lock_hold;
    reg         unlocked;
    reg  [2:0]  state;
    reg  [3:0]  settle_cnt;
    reg         rst_seen;
    reg  [15:0] clock_divider_control;
    reg  [2:0]  ratio_act;
    reg  [2:0]  rcps_act;
    reg  [1:0]  sysps_act;
    reg  [7:0]  ratio_cnt;
    reg  [7:0]  rc_cnt;
    reg  [2:0]  sys_cnt;
    wire [15:0] oscctl_rd;
    wire        wr_osc;
    wire        wr_div;
    wire        frozen;
    wire        pll_mode;
    wire [7:0]  ratio_lim;
    wire [7:0]  rc_lim;
    wire [2:0]  sys_lim;
    wire        ctl_wr;
    wire        wr_unlock;
    wire        key_match;
    wire        cfg_load;
    wire        req_wr_ok;
    wire        sw_start_req;
    wire        sw_redundant;
    wire        sw_valid;
    wire        settle_done;
    wire        pin_lock_stuck;
    wire        fail_set;
    wire        fail_clr;
    wire        ratio_wrap;
    wire        rc_wrap;
    wire        sys_wrap;
    reg  [2:0]  next_state;
    reg  [3:0]  next_settle_cnt;
    reg  [15:0] next_rdata;

    assign switch_allowed    = ~switch_monitor_cfg[1]; // RULE1
    assign fail_safe_monitor = (switch_monitor_cfg == 2'h0); // RULE2
    assign primary_mode      = primary_mode_cfg; // RULE3
    assign active_source     = cur_src; // RULE3
    assign frozen            = fail_safe_monitor & selection_lock; // RULE8
    assign pll_mode          = (cur_src == `OSC_SRC_PRIPLL) | (cur_src == `OSC_SRC_RC_WITH_PLL_MODE);
    assign primary_osc_run   = ~sleep_mode | primary_sleep_run; // RULE13
    assign secondary_osc_en  = secondary_enable; // RULE14
    assign pll96_en          = clock_divider_control[`OSC_BIT_PLL96_ENABLE]; // RULE23
    assign display_clk_source_sel = clock_divider_control[`OSC_BIT_DISPSEL];
    assign wr_osc = reg_wr & (reg_addr == `OSC_ADDR_OSCCTL);
    assign wr_div = reg_wr & (reg_addr == `OSC_ADDR_CLOCK_DIVIDER_CONTROL);
    assign ctl_wr         = wr_osc & ~rst_seen;
    assign wr_unlock      = reg_wr & (reg_addr == `OSC_ADDR_UNLOCK);
    assign key_match      = (reg_wdata == `OSC_UNLOCK_KEY);
    assign cfg_load       = rst_seen;
    assign req_wr_ok      = ctl_wr & ~frozen & (state == ST_IDLE); // RULE8
    assign sw_start_req   = ctl_wr & reg_wdata[`OSC_BIT_SWREQ] & switch_allowed & ~frozen
                            & (state == ST_IDLE); // RULE1 RULE26
    assign sw_redundant   = sw_start_req & (reg_wdata[`OSC_REQ_HI:`OSC_REQ_LO] == cur_src);
    assign sw_valid       = sw_start_req & ~sw_redundant;
    assign settle_done    = (settle_cnt == `OSC_SETTLE_CYCLES - 4'h1);
    assign pin_lock_stuck = one_way_pin_lock_cfg & pin_map_lock; // RULE9
    assign fail_set       = clock_failed & fail_safe_monitor; // RULE12
    assign fail_clr       = (wr_osc & ~reg_wdata[`OSC_BIT_FAIL]) | sw_valid; // RULE12

    assign oscctl_rd = {1'b0, cur_src, 1'b0, req_src, selection_lock, pin_map_lock,
                        lock_hold, 1'b0, clock_fail_flag, primary_sleep_run,
                        secondary_enable, switch_request}; // RULE5 RULE22

    // reset marker: first cycle after release loads configuration
    always @(posedge mclk) begin
        if (!rst_b)
            rst_seen <= 1'b1;
        else
            rst_seen <= 1'b0;
    end

    // current and requested source fields
    always @(posedge mclk) begin
        if (!rst_b) begin
            cur_src <= 3'h7; // RULE4
            req_src <= 3'h7;
        end else if (cfg_load) begin
            cur_src <= initial_source_cfg; // RULE7
            req_src <= initial_source_cfg; // RULE7
        end else begin
            if (req_wr_ok)
                req_src <= reg_wdata[`OSC_REQ_HI:`OSC_REQ_LO]; // RULE6
            if (state == ST_DONE)
                cur_src <= req_src; // RULE25
        end
    end

    // unlock key: arms the next control write only
    always @(posedge mclk) begin
        if (!rst_b)
            unlocked <= 1'b0;
        else if (wr_unlock)
            unlocked <= key_match;
        else if (wr_osc)
            unlocked <= 1'b0;
    end

    // selection lock: settable only, cleared by reset
    always @(posedge mclk) begin
        if (!rst_b)
            selection_lock <= 1'b0;
        else if (ctl_wr && fail_safe_monitor && reg_wdata[`OSC_BIT_SELLOCK])
            selection_lock <= 1'b1; // RULE8
    end

    // pin map lock: needs the key, one-way option blocks clearing
    always @(posedge mclk) begin
        if (!rst_b)
            pin_map_lock <= 1'b0;
        else if (ctl_wr && unlocked && !pin_lock_stuck)
            pin_map_lock <= reg_wdata[`OSC_BIT_PINLOCK]; // RULE9
    end

    // plain control bits
    always @(posedge mclk) begin
        if (!rst_b) begin
            primary_sleep_run <= 1'b0;
            secondary_enable  <= 1'b0;
        end else if (ctl_wr) begin
            primary_sleep_run <= reg_wdata[`OSC_BIT_PRISLEEP]; // RULE13
            secondary_enable  <= reg_wdata[`OSC_BIT_SECEN]; // RULE14
        end
    end

    // clock fail flag: hardware set wins over any clear
    always @(posedge mclk) begin
        if (!rst_b)
            clock_fail_flag <= 1'b0;
        else if (fail_set)
            clock_fail_flag <= 1'b1; // RULE12
        else if (fail_clr)
            clock_fail_flag <= 1'b0; // RULE12
    end

    // switch request bit: held from a valid start until change-over
    always @(posedge mclk) begin
        if (!rst_b)
            switch_request <= 1'b0;
        else if (sw_valid)
            switch_request <= 1'b1; // RULE15
        else if (sw_redundant)
            switch_request <= 1'b0; // RULE24
        else if (state == ST_DONE)
            switch_request <= 1'b0; // RULE15
    end

    // switch sequencer: next state
    always @* begin
        next_state      = state;
        next_settle_cnt = settle_cnt;
        case (state)
            ST_IDLE: begin
                if (sw_valid) begin
                    next_state      = ST_SETTLE;
                    next_settle_cnt = 4'h0;
                end
            end
            ST_SETTLE: begin
                if (new_clk_tick) begin
                    next_settle_cnt = settle_cnt + 4'h1;
                    if (settle_done)
                        next_state = ST_DONE; // RULE25
                end
            end
            ST_DONE: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // switch sequencer: state registers
    always @(posedge mclk) begin
        if (!rst_b) begin
            state      <= ST_IDLE;
            settle_cnt <= 4'h0;
        end else begin
            state      <= next_state;
            settle_cnt <= next_settle_cnt;
        end
    end

    // pll lock status
    always @(posedge mclk) begin
        if (!rst_b)
            lock_hold <= 1'b0;
        else if (state != ST_IDLE || !pll_mode || !pll96_en)
            lock_hold <= 1'b0; // RULE11
        else
            lock_hold <= pll_locked | pll_timer_done; // RULE10
    end

    // divider register
    always @(posedge mclk) begin
        if (!rst_b) begin
            clock_divider_control <= `OSC_CLOCK_DIVIDER_CONTROL_RST; // RULE19
        end else begin
            if (wr_div)
                clock_divider_control <= reg_wdata & `OSC_CLOCK_DIVIDER_CONTROL_WMASK;
            if (irq_any && clock_divider_control[`OSC_BIT_ROI] && !(wr_div && reg_wdata[`OSC_BIT_ROI] == 1'b0))
                clock_divider_control[`OSC_BIT_RATIO_EN] <= 1'b0; // RULE16
        end
    end

    // read data mux
    always @* begin
        next_rdata = 16'h0000;
        if (reg_rd) begin
            case (reg_addr)
                `OSC_ADDR_OSCCTL: next_rdata = oscctl_rd; // RULE5 RULE22
                `OSC_ADDR_CLOCK_DIVIDER_CONTROL: next_rdata = clock_divider_control;
                default:          next_rdata = 16'h0000;
            endcase
        end
    end

    // read data register: valid one cycle after the strobe
    always @(posedge mclk) begin
        if (!rst_b)
            reg_rdata <= 16'h0000;
        else
            reg_rdata <= next_rdata;
    end

    // divide limits and period ends
    assign ratio_lim  = clock_divider_control[`OSC_BIT_RATIO_EN] ? ((8'h01 << ratio_act) - 8'h01)
                                                  : 8'h00; // RULE17 RULE18
    assign rc_lim     = (rcps_act == 3'h7) ? 8'hFF : ((8'h01 << rcps_act) - 8'h01); // RULE19
    assign sys_lim    = (3'h1 << sysps_act) - 3'h1; // RULE20
    assign ratio_wrap = (ratio_cnt >= ratio_lim);
    assign rc_wrap    = rc_clk_tick & (rc_cnt >= rc_lim);
    assign sys_wrap   = sys_clk_tick & (sys_cnt >= sys_lim);

    // peripheral ratio divider; setting latched at period end
    always @(posedge mclk) begin
        if (!rst_b) begin
            ratio_act   <= 3'h0;
            ratio_cnt   <= 8'h00;
            periph_tick <= 1'b0;
        end else if (ratio_wrap) begin
            ratio_act   <= clock_divider_control[`OSC_RATIO_HI:`OSC_RATIO_LO]; // RULE27
            ratio_cnt   <= 8'h00;
            periph_tick <= 1'b1;
        end else begin
            ratio_cnt   <= ratio_cnt + 8'h01;
            periph_tick <= 1'b0;
        end
    end

    // rc postscaler; setting latched at period end
    always @(posedge mclk) begin
        if (!rst_b) begin
            rcps_act    <= 3'h1;
            rc_cnt      <= 8'h00;
            rc_div_tick <= 1'b0;
        end else if (rc_wrap) begin
            rcps_act    <= clock_divider_control[`OSC_RCPS_HI:`OSC_RCPS_LO]; // RULE27
            rc_cnt      <= 8'h00;
            rc_div_tick <= 1'b1;
        end else begin
            if (rc_clk_tick)
                rc_cnt <= rc_cnt + 8'h01;
            rc_div_tick <= 1'b0;
        end
    end

    // system clock postscaler; setting latched at period end
    always @(posedge mclk) begin
        if (!rst_b) begin
            sysps_act    <= 2'h0;
            sys_cnt      <= 3'h0;
            sys_div_tick <= 1'b0;
        end else if (sys_wrap) begin
            sysps_act    <= clock_divider_control[`OSC_SYSPS_HI:`OSC_SYSPS_LO]; // RULE27
            sys_cnt      <= 3'h0;
            sys_div_tick <= 1'b1;
        end else begin
            if (sys_clk_tick)
                sys_cnt <= sys_cnt + 3'h1;
            sys_div_tick <= 1'b0;
        end
    end
endmodule // osc_ctrl

// File: tb/osc_ctrl_asserts.sv
// Purpose: port checks of osc_ctrl
// Assumes: configuration inputs change only during reset
// Notes:   bound to every osc_ctrl instance
`timescale 1ns/100ps
module osc_ctrl_asserts (
    input wire        mclk,
    input wire        rst_b,
    input wire [1:0]  reg_addr,
    input wire [15:0] reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [15:0] reg_rdata,
    input wire [1:0]  switch_monitor_cfg,
    input wire [1:0]  primary_mode_cfg,
    input wire [2:0]  initial_source_cfg,
    input wire        sleep_mode,
    input wire [2:0]  active_source,
    input wire [1:0]  primary_mode,
    input wire        switch_allowed,
    input wire        fail_safe_monitor,
    input wire        primary_osc_run,
    input wire        secondary_osc_en,
    input wire        pll96_en
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    AST_SW_ALLOWED: assert property (switch_allowed == !switch_monitor_cfg[1])
        else $error("switch enable mismatch");
    AST_MONITOR_EN: assert property (fail_safe_monitor == (switch_monitor_cfg == 2'h0))
        else $error("monitor enable mismatch");
    AST_MODE_PASS: assert property (primary_mode == primary_mode_cfg)
        else $error("primary mode mismatch");
    AST_RST_SOURCE: assert property ($rose(rst_b) |=> active_source == $past(initial_source_cfg))
        else $error("source not loaded after reset");
    AST_PRI_AWAKE: assert property (!sleep_mode |-> primary_osc_run)
        else $error("primary stopped while awake");
    AST_UNIMPL_ZERO: assert property ($past(reg_rd) && $past(reg_addr) == 2'h0 |->
        {reg_rdata[15], reg_rdata[11], reg_rdata[4]} == 3'h0) else $error("unimplemented bit set");
    AST_REQ_DISABLED: assert property (switch_monitor_cfg[1] && $past(reg_rd)
        && $past(reg_addr) == 2'h0 |-> !reg_rdata[0]) else $error("request bit set while disabled");
    AST_PLL_EN: assert property (reg_wr && reg_addr == 2'h1 |=> pll96_en == $past(reg_wdata[5]))
        else $error("pll enable not written");
    AST_SEC_HOLD: assert property (!(reg_wr && reg_addr == 2'h0) |=> $stable(secondary_osc_en))
        else $error("secondary enable changed without write");
    AST_SRC_HOLD: assert property ($past(rst_b) && !switch_allowed |=> $stable(active_source))
        else $error("source changed while switching disabled");
    cover property (reg_wr && reg_addr == 2'h2);
    cover property (fail_safe_monitor && $changed(active_source));
    cover property (pll96_en && reg_rd);
endmodule // osc_ctrl_asserts

bind osc_ctrl osc_ctrl_asserts i_osc_ctrl_asserts (.mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .switch_monitor_cfg, .primary_mode_cfg, .initial_source_cfg, .sleep_mode,
    .active_source, .primary_mode, .switch_allowed, .fail_safe_monitor, .primary_osc_run,
    .secondary_osc_en, .pll96_en);

// File: tb/osc_ctrl_test.sv
// Purpose: register-level test of osc_ctrl
// Assumes: strobe bus, read data in the cycle after the read strobe
// Notes:   configuration inputs change only while reset is held
`timescale 1ns/100ps
module osc_ctrl_test;
    reg         mclk, rst_b, reg_wr, reg_rd, ow_cfg, pll_locked, clock_failed;
    reg         new_clk_tick, irq_any, sleep_mode, pll_timer_done;
    reg  [1:0]  reg_addr, sm_cfg, pm_cfg;
    reg  [2:0]  src_cfg;
    reg  [15:0] reg_wdata;
    wire [15:0] reg_rdata;
    wire [2:0]  active_source;
    wire [1:0]  primary_mode;
    wire        switch_allowed, fail_safe_monitor, primary_osc_run, secondary_osc_en;
    wire        pll96_en, disp_sel, periph_tick, rc_div_tick, sys_div_tick;
    integer     n_errors, check_count, cycles, cp, cr, cs;
    osc_ctrl i_osc_ctrl (.mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .switch_monitor_cfg(sm_cfg), .primary_mode_cfg(pm_cfg), .initial_source_cfg(src_cfg),
        .one_way_pin_lock_cfg(ow_cfg), .pll_locked, .pll_timer_done, .clock_failed,
        .new_clk_tick, .irq_any, .sleep_mode, .rc_clk_tick(1'b1), .sys_clk_tick(1'b1),
        .active_source, .primary_mode, .switch_allowed, .fail_safe_monitor, .primary_osc_run,
        .secondary_osc_en, .pll96_en, .display_clk_source_sel(disp_sel), .periph_tick,
        .rc_div_tick, .sys_div_tick);
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    task chk(input string nm, input [15:0] got, input [15:0] exp);
        check_count = check_count + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge mclk);
    endtask
    task wr(input [1:0] a, input [15:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task rd(input [1:0] a, input [15:0] exp);
        @(posedge mclk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        chk("rdata", reg_rdata, exp);
        @(posedge mclk);
    endtask
    task do_reset(input [1:0] sm, input [1:0] pm, input [2:0] src);
        @(posedge mclk);
        rst_b <= 1'b0; sm_cfg <= sm; pm_cfg <= pm; src_cfg <= src;
        tick(20);
        rst_b <= 1'b1;
        tick(3);
    endtask
    task pulse_new(input integer n);
        repeat (n) begin
            @(posedge mclk);
            new_clk_tick <= 1'b1;
            @(posedge mclk);
            new_clk_tick <= 1'b0;
        end
    endtask
    task count_ticks(input integer n);
        cp = 0;
        cr = 0;
        cs = 0;
        repeat (n) begin
            @(negedge mclk);
            if (periph_tick === 1'b1) cp = cp + 1;
            if (rc_div_tick === 1'b1) cr = cr + 1;
            if (sys_div_tick === 1'b1) cs = cs + 1;
        end
        @(posedge mclk);
    endtask
    task end_sim;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            n_errors = n_errors + 1;
            end_sim;
        end
    end
    initial begin
        n_errors = 0; check_count = 0; cycles = 0; rst_b = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0;
        reg_addr = 2'h0; reg_wdata = 16'h0000; sm_cfg = 2'h3; pm_cfg = 2'h3; src_cfg = 3'h7;
        ow_cfg = 1'b1; pll_locked = 1'b0; clock_failed = 1'b0; new_clk_tick = 1'b0;
        irq_any = 1'b0; sleep_mode = 1'b0; pll_timer_done = 1'b0;
        do_reset(2'h3, 2'h3, 3'h7);
        rd(2'h0, 16'h7700);
        rd(2'h1, 16'h0100);
        rd(2'h3, 16'h0000);
        wr(2'h0, 16'h0001);
        rd(2'h0, 16'h7000);
        wr(2'h0, 16'h0702);
        rd(2'h0, 16'h7702);
        sleep_mode <= 1'b1;
        tick(2);
        chk("pri_run", primary_osc_run, 16'h0);
        wr(2'h0, 16'h0706);
        tick(1);
        chk("pri_run", primary_osc_run, 16'h1);
        wr(2'h1, 16'hFFFF);
        rd(2'h1, 16'hFFF0);
        tick(16);
        count_ticks(64);
        chk("sys_div", cs, 16'h8);
        chk("periph", cp, 16'h0);
        chk("rc_div", cr, 16'h0);
        irq_any <= 1'b1;
        tick(1);
        irq_any <= 1'b0;
        rd(2'h1, 16'hF7F0);
        count_ticks(16);
        chk("periph", cp, 16'h10);
        chk("sys_div", cs, 16'h2);
        wr(2'h1, 16'h7FF0);
        irq_any <= 1'b1;
        tick(1);
        irq_any <= 1'b0;
        rd(2'h1, 16'h7FF0);
        $display("test 1 done");
        do_reset(2'h0, 2'h1, 3'h3);
        rd(2'h0, 16'h3300);
        wr(2'h1, 16'h0120);
        pll_locked <= 1'b1;
        tick(2);
        rd(2'h0, 16'h3320);
        pll_locked <= 1'b0;
        pll_timer_done <= 1'b1;
        tick(2);
        rd(2'h0, 16'h3320);
        pll_timer_done <= 1'b0;
        wr(2'h0, 16'h0001);
        rd(2'h0, 16'h3001);
        pulse_new(9);
        rd(2'h0, 16'h3001);
        pulse_new(1);
        tick(3);
        rd(2'h0, 16'h0000);
        chk("active", active_source, 16'h0);
        wr(2'h0, 16'h0001);
        rd(2'h0, 16'h0000);
        clock_failed <= 1'b1;
        tick(1);
        clock_failed <= 1'b0;
        rd(2'h0, 16'h0008);
        wr(2'h0, 16'h0000);
        rd(2'h0, 16'h0000);
        wr(2'h0, 16'h0040);
        rd(2'h0, 16'h0000);
        wr(2'h2, 16'h55AA);
        wr(2'h0, 16'h0040);
        rd(2'h0, 16'h0040);
        wr(2'h2, 16'h55AA);
        wr(2'h0, 16'h0000);
        rd(2'h0, 16'h0040);
        wr(2'h0, 16'h00C0);
        wr(2'h0, 16'h02C1);
        rd(2'h0, 16'h00C0);
        wr(2'h1, 16'h1900);
        tick(8);
        count_ticks(16);
        chk("periph", cp, 16'h8);
        chk("rc_div", cr, 16'h8);
        chk("sys_div", cs, 16'h10);
        $display("test 2 done");
        end_sim;
    end
endmodule // osc_ctrl_test
